// ==== ppc_regs.svh ====
// Register select codes, control bit positions and reset values of the parallel port block
`ifndef PPC_REGS_SVH
`define PPC_REGS_SVH

// ----------------------------------------------------------------------
// Register select codes
// ----------------------------------------------------------------------
`define SEL_A_DATA      2'h0
`define SEL_A_CONTROL   2'h1
`define SEL_B_DATA      2'h2
`define SEL_B_CONTROL   2'h3

// ----------------------------------------------------------------------
// Control register field positions
// ----------------------------------------------------------------------
`define CTL_IRQ1_EN     0
`define CTL_IRQ1_EDGE   1
`define CTL_DATA_SEL    2
`define CTL_AUX_B3      3
`define CTL_AUX_B4      4
`define CTL_AUX_OUT     5
`define CTL_FLAG_AUX    6
`define CTL_FLAG_IRQ1   7

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CTL_RESET       6'h00
`define BYTE_RESET      8'h00

`endif

// ==== ppc_pkg.sv ====
// Types shared by the parallel port control block
package ppc_pkg;
  // One byte of port or bus data
  typedef logic [7:0] byte_t;
  // Writable part of a control register
  typedef logic [5:0] ctl_t;
endpackage

// ==== parallel_port_control_bits.sv ====
// Dual 8-bit parallel port: data, direction and control registers with edge flags
`timescale 1ns/100ps
`include "ppc_regs.svh"

module parallel_port_control_bits (
  input  wire logic        clk,                       // System clock, 25 MHz
  input  wire logic        sys_rst,                   // Asynchronous reset, active high
  input  wire logic        chip_select,               // Access strobe for this block
  input  wire logic        read_not_write,            // 1 = read, 0 = write
  input  wire logic        register_select_low,       // Register select bit 0
  input  wire logic        register_select_high,      // Register select bit 1
  input  wire ppc_pkg::byte_t write_data,             // Host write data
  output ppc_pkg::byte_t   read_data,                 // Host read data, registered
  input  wire ppc_pkg::byte_t port_a_in,              // Port A pin levels
  output ppc_pkg::byte_t   port_a_out,                // Port A output register
  output ppc_pkg::byte_t   port_a_oe_n,               // Port A enable, low = drive
  input  wire ppc_pkg::byte_t port_b_in,              // Port B pin levels
  output ppc_pkg::byte_t   port_b_out,                // Port B output register
  output ppc_pkg::byte_t   port_b_oe_n,               // Port B enable, low = drive
  input  wire logic        side_a_irq_input,          // Side A interrupt input pin
  input  wire logic        side_b_irq_input,          // Side B interrupt input pin
  input  wire logic        side_a_aux_line_in,        // Side A aux line level
  output logic             side_a_aux_line_out,       // Side A aux line drive value
  output logic             side_a_aux_line_oe_n,      // Side A aux enable, low = drive
  input  wire logic        side_b_aux_line_in,        // Side B aux line level
  output logic             side_b_aux_line_out,       // Side B aux line drive value
  output logic             side_b_aux_line_oe_n,      // Side B aux enable, low = drive
  output logic             side_a_interrupt_request_n, // Side A request, open-drain level
  output logic             side_b_interrupt_request_n  // Side B request, open-drain level
);

  // ----------------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------------

  // Register select bus, A/B side and data/control split
  logic [1:0] sel;
  assign sel = {register_select_high, register_select_low};

  // Per side: [0] = side A, [1] = side B
  ppc_pkg::ctl_t   ctl_q      [2];                    // Writable control bits 0..5
  logic            flag1_q    [2];                    // Flag from dedicated input
  logic            flag2_q    [2];                    // Flag from aux line
  ppc_pkg::byte_t  out_q      [2];                    // Output registers
  ppc_pkg::byte_t  dir_q      [2];                    // Direction registers, 1 = output
  ppc_pkg::byte_t  pin_in     [2];                    // Synchronised port pins
  logic            irq_pin    [2];                    // Synchronised dedicated inputs
  logic            aux_pin    [2];                    // Synchronised aux lines
  logic            data_rd    [2];                    // Peripheral data read strobe

  // True when a select code addresses a side's data/direction slot
  function automatic logic is_data_slot(input logic [1:0] s, input int side);
    is_data_slot = (s == (side == 0 ? `SEL_A_DATA : `SEL_B_DATA));
  endfunction

  // True when a select code addresses a side's control register
  function automatic logic is_ctl_slot(input logic [1:0] s, input int side);
    is_ctl_slot = (s == (side == 0 ? `SEL_A_CONTROL : `SEL_B_CONTROL));
  endfunction

  // ----------------------------------------------------------------------
  // Per-side logic
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_side
      ppc_pkg::byte_t pin_s1_q;                       // First stage, read only by second
      ppc_pkg::byte_t pin_s2_q;                       // Second stage
      logic [1:0]     irq_s_q;                        // Dedicated input synchroniser
      logic [1:0]     aux_s_q;                        // Aux line synchroniser
      logic           irq_prev_q;                     // Previous dedicated input level
      logic           aux_prev_q;                     // Previous aux line level
      logic           wr_data;                        // Write to data slot
      logic           wr_ctl;                         // Write to control slot
      logic           irq_edge;                       // Active edge on dedicated input
      logic           aux_edge;                       // Active edge on aux line

      // Pins come from outside the clock domain, two flops before use
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          pin_s1_q <= `BYTE_RESET;
          pin_s2_q <= `BYTE_RESET;
          irq_s_q  <= 2'h0;
          aux_s_q  <= 2'h0;
        end else begin
          pin_s1_q <= (g == 0) ? port_a_in : port_b_in;
          pin_s2_q <= pin_s1_q;
          irq_s_q  <= {irq_s_q[0], (g == 0) ? side_a_irq_input : side_b_irq_input};
          aux_s_q  <= {aux_s_q[0], (g == 0) ? side_a_aux_line_in : side_b_aux_line_in};
        end
      end
      assign pin_in[g]  = pin_s2_q;
      assign irq_pin[g] = irq_s_q[1];
      assign aux_pin[g] = aux_s_q[1];

      // Strobes for this side
      assign wr_data    = chip_select && !read_not_write && is_data_slot(sel, g);
      assign wr_ctl     = chip_select && !read_not_write && is_ctl_slot(sel, g);
      assign data_rd[g] = chip_select && read_not_write && is_data_slot(sel, g)
                          && ctl_q[g][`CTL_DATA_SEL];

      // Edge history; the previous level conditions the edge detector
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          irq_prev_q <= 1'b0;
          aux_prev_q <= 1'b0;
        end else begin
          irq_prev_q <= irq_pin[g];
          aux_prev_q <= aux_pin[g];
        end
      end

      // Edge select: bit 1 high = rising, low = falling
      assign irq_edge = ctl_q[g][`CTL_IRQ1_EDGE] ? (irq_pin[g] && !irq_prev_q)
                                                 : (!irq_pin[g] && irq_prev_q);
      // Aux line as input behaves like the dedicated input; bit 4 picks the edge
      assign aux_edge = !ctl_q[g][`CTL_AUX_OUT] &&
                        (ctl_q[g][`CTL_AUX_B4] ? (aux_pin[g] && !aux_prev_q)
                                               : (!aux_pin[g] && aux_prev_q));

      // Control bits 0..5, host writable; reset leaves everything input and disabled
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          ctl_q[g] <= `CTL_RESET;
        end else if (wr_ctl) begin
          ctl_q[g] <= write_data[5:0];                // Bits 6,7 of the write dropped
        end
      end

      // Flags: an edge in the clearing cycle wins so no event is lost
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          flag1_q[g] <= 1'b0;
          flag2_q[g] <= 1'b0;
        end else begin
          if (irq_edge) begin
            flag1_q[g] <= 1'b1;
          end else if (data_rd[g]) begin
            flag1_q[g] <= 1'b0;
          end
          if (aux_edge) begin
            flag2_q[g] <= 1'b1;                       // Only while aux is an input
          end else if (data_rd[g] || ctl_q[g][`CTL_AUX_OUT]) begin
            flag2_q[g] <= 1'b0;
          end
        end
      end

      // Output and direction registers, chosen by bit 2
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          out_q[g] <= `BYTE_RESET;
          dir_q[g] <= `BYTE_RESET;
        end else if (wr_data) begin
          if (ctl_q[g][`CTL_DATA_SEL]) begin
            out_q[g] <= write_data;
          end else begin
            dir_q[g] <= write_data;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Host read path
  // ----------------------------------------------------------------------

  // Peripheral read: output bits show the latch, input bits show the pin
  function automatic ppc_pkg::byte_t periph_view(input int side);
    periph_view = (out_q[side] & dir_q[side]) | (pin_in[side] & ~dir_q[side]);
  endfunction

  // Read data is registered; it appears one clock after the strobe
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      read_data <= `BYTE_RESET;
    end else if (chip_select && read_not_write) begin
      case (sel)
        `SEL_A_DATA:    read_data <= ctl_q[0][`CTL_DATA_SEL] ? periph_view(0) : dir_q[0];
        `SEL_A_CONTROL: read_data <= {flag1_q[0], flag2_q[0], ctl_q[0]};
        `SEL_B_DATA:    read_data <= ctl_q[1][`CTL_DATA_SEL] ? periph_view(1) : dir_q[1];
        `SEL_B_CONTROL: read_data <= {flag1_q[1], flag2_q[1], ctl_q[1]};
        default:        read_data <= `BYTE_RESET;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Pins and interrupt requests
  // ----------------------------------------------------------------------

  // Port drives follow the direction registers
  assign port_a_out  = out_q[0];
  assign port_b_out  = out_q[1];
  assign port_a_oe_n = ~dir_q[0];
  assign port_b_oe_n = ~dir_q[1];

  // Aux line in output mode drives the level held in bit 3; the handshake
  // strobe modes are not modelled and stay a provisional simplification
  assign side_a_aux_line_oe_n = ~ctl_q[0][`CTL_AUX_OUT];
  assign side_b_aux_line_oe_n = ~ctl_q[1][`CTL_AUX_OUT];
  assign side_a_aux_line_out  = ctl_q[0][`CTL_AUX_B3];
  assign side_b_aux_line_out  = ctl_q[1][`CTL_AUX_B3];

  // Requests low while an enabled flag stands; aux flag enabled by bit 3
  assign side_a_interrupt_request_n =
    !((flag1_q[0] && ctl_q[0][`CTL_IRQ1_EN]) ||
      (flag2_q[0] && ctl_q[0][`CTL_AUX_B3] && !ctl_q[0][`CTL_AUX_OUT]));
  assign side_b_interrupt_request_n =
    !((flag1_q[1] && ctl_q[1][`CTL_IRQ1_EN]) ||
      (flag2_q[1] && ctl_q[1][`CTL_AUX_B3] && !ctl_q[1][`CTL_AUX_OUT]));

endmodule

// ==== parallel_port_control_bits_asserts.sv ====
// Port-level checker of the parallel port control block
`timescale 1ns/100ps
module parallel_port_control_bits_asserts (
  input wire logic           clk, sys_rst, chip_select, read_not_write,
  input wire logic           register_select_low, register_select_high,
  input wire ppc_pkg::byte_t write_data, read_data, port_a_out, port_a_oe_n, port_b_oe_n,
  input wire logic           side_a_aux_line_oe_n, side_b_aux_line_out, side_b_aux_line_oe_n,
  input wire logic           side_a_interrupt_request_n, side_b_interrupt_request_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire       wr  = chip_select && !read_not_write;  // Write taken at this edge
  wire [1:0] sel = {register_select_high, register_select_low};
  logic a_dsel_q, a_en_q, b_en_q;  // Shadow of bit 2 and of the enable bits
  // Shadow copies; enable is a superset so a request may never appear without one
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) {a_dsel_q, a_en_q, b_en_q} <= 3'h0;
    else if (wr && sel == 2'h1) {a_dsel_q, a_en_q} <= {write_data[2], write_data[0] | write_data[3]};
    else if (wr && sel == 2'h3) b_en_q <= write_data[0] | write_data[3];
  end
  property p_rst; disable iff (1'b0) sys_rst |-> side_a_interrupt_request_n &&
    side_b_interrupt_request_n && port_a_oe_n == 8'hFF && port_b_oe_n == 8'hFF &&
    side_a_aux_line_oe_n && side_b_aux_line_oe_n; endproperty
  a_rst: assert property (p_rst) else $error("Outputs not idle in reset");
  property p_a_aux; wr && sel == 2'h1 |=> side_a_aux_line_oe_n == !$past(write_data[5]); endproperty
  a_a_aux: assert property (p_a_aux) else $error("Aux A direction wrong");
  property p_b_aux; wr && sel == 2'h3 |=> side_b_aux_line_out == $past(write_data[3]) &&
    side_b_aux_line_oe_n == !$past(write_data[5]); endproperty
  a_b_aux: assert property (p_b_aux) else $error("Aux B function wrong");
  property p_a_dir; wr && sel == 2'h0 && !a_dsel_q |=> port_a_oe_n == ~$past(write_data); endproperty
  a_a_dir: assert property (p_a_dir) else $error("Direction write lost");
  property p_a_out; wr && sel == 2'h0 && a_dsel_q |=> port_a_out == $past(write_data); endproperty
  a_a_out: assert property (p_a_out) else $error("Output write lost");
  property p_req_a; !a_en_q |-> side_a_interrupt_request_n; endproperty
  a_req_a: assert property (p_req_a) else $error("Request A while disabled");
  property p_req_b; !b_en_q |-> side_b_interrupt_request_n; endproperty
  a_req_b: assert property (p_req_b) else $error("Request B while disabled");
  property p_rb_a; wr && sel == 2'h1 ##1 chip_select && read_not_write && sel == 2'h1 |=>
    read_data[5:0] == $past(write_data[5:0], 2); endproperty
  a_rb_a: assert property (p_rb_a) else $error("Control A readback wrong");
  property p_rb_b; wr && sel == 2'h3 ##1 chip_select && read_not_write && sel == 2'h3 |=>
    read_data[5:0] == $past(write_data[5:0], 2); endproperty
  a_rb_b: assert property (p_rb_b) else $error("Control B readback wrong");
endmodule
bind parallel_port_control_bits parallel_port_control_bits_asserts i_chk (.clk(clk),
  .sys_rst(sys_rst), .chip_select(chip_select), .read_not_write(read_not_write),
  .register_select_low(register_select_low), .register_select_high(register_select_high),
  .write_data(write_data), .read_data(read_data), .port_a_out(port_a_out),
  .port_a_oe_n(port_a_oe_n), .port_b_oe_n(port_b_oe_n),
  .side_a_aux_line_oe_n(side_a_aux_line_oe_n), .side_b_aux_line_out(side_b_aux_line_out),
  .side_b_aux_line_oe_n(side_b_aux_line_oe_n),
  .side_a_interrupt_request_n(side_a_interrupt_request_n),
  .side_b_interrupt_request_n(side_b_interrupt_request_n));

// ==== host_bus_model.sv ====
// Host processor model: one access, or a write followed at once by a read
`timescale 1ns/100ps
module host_bus_model (
  input  wire logic           clk,
  output logic                cs, rnw, sel_lo, sel_hi,
  output ppc_pkg::byte_t      wdata,
  input  wire ppc_pkg::byte_t rdata
);
  initial {cs, rnw, sel_lo, sel_hi, wdata} = 12'h000;
  // Read data is registered at the taking edge and stands, so it is taken a cycle later
  task automatic acc(input logic [1:0] sel, input logic wr, input ppc_pkg::byte_t wd,
                     output ppc_pkg::byte_t rd);
    @(posedge clk);
    {sel_hi, sel_lo} <= sel;
    cs <= 1'b1;
    rnw <= !wr;
    wdata <= wd;
    @(posedge clk);
    if (wr) begin
      rnw <= 1'b1;
      @(posedge clk);
    end
    cs <= 1'b0;
    @(posedge clk);
    rd = rdata;
  endtask
endmodule

// ==== parallel_port_control_bits_tb_top.sv ====
// Self-checking bench of the parallel port control block
`timescale 1ns/100ps
module parallel_port_control_bits_tb_top;
  logic clk = 1'b0, sys_rst = 1'b0, cs, rnw, sl, sh, ao_a, ae_a, ao_b, ae_b, rq_a, rq_b;
  logic [1:0] irq = 2'h0, aux = 2'h0;  // Peripheral-side interrupt and aux levels
  ppc_pkg::byte_t wd, rd, r, pa_o, pa_e, pb_o, pb_e, dir, outv, pin_a = 8'h00, pin_b = 8'h00;
  ppc_pkg::byte_t rnd = 8'h33;  // Random source state
  int n_mismatch = 0, checked = 0, s;
  always #20 clk = ~clk;
  host_bus_model i_host (.clk(clk), .cs(cs), .rnw(rnw), .sel_lo(sl), .sel_hi(sh),
    .wdata(wd), .rdata(rd));
  // Pin levels resolved from the block's enables; the bench drives every released pin
  parallel_port_control_bits i_dut (.clk(clk), .sys_rst(sys_rst), .chip_select(cs),
    .read_not_write(rnw), .register_select_low(sl), .register_select_high(sh),
    .write_data(wd), .read_data(rd), .port_a_in((pa_o & ~pa_e) | (pin_a & pa_e)),
    .port_a_out(pa_o), .port_a_oe_n(pa_e), .port_b_in((pb_o & ~pb_e) | (pin_b & pb_e)),
    .port_b_out(pb_o), .port_b_oe_n(pb_e), .side_a_irq_input(irq[0]),
    .side_b_irq_input(irq[1]), .side_a_aux_line_in(ae_a ? aux[0] : ao_a),
    .side_a_aux_line_out(ao_a), .side_a_aux_line_oe_n(ae_a),
    .side_b_aux_line_in(ae_b ? aux[1] : ao_b), .side_b_aux_line_out(ao_b),
    .side_b_aux_line_oe_n(ae_b), .side_a_interrupt_request_n(rq_a),
    .side_b_interrupt_request_n(rq_b));
  function automatic ppc_pkg::byte_t lfsr(input ppc_pkg::byte_t v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic chk(input ppc_pkg::byte_t got, input ppc_pkg::byte_t exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    if (n_mismatch == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Write a control value, read it back at once, then check the request level
  task automatic ctl(input ppc_pkg::byte_t v, input ppc_pkg::byte_t exp, input logic req);
    i_host.acc(2'(2 * s + 1), 1'b1, v, r);
    chk(r, exp);
    chk({7'h00, s ? rq_b : rq_a}, {7'h00, req});
  endtask
  // Hang guard: the main sequence needs far fewer cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    // Raised by NBA at time 0 so the asynchronous reset sees a real edge
    sys_rst <= 1'b1;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    for (s = 0; s < 2; s++) begin
      i_host.acc(2'(2 * s + 1), 1'b0, 8'h00, r);
      chk(r, 8'h00);
      chk(s ? pb_e : pa_e, 8'hFF);
      repeat (4) begin
        rnd = lfsr(rnd);
        ctl(rnd | 8'hC0, {2'h0, rnd[5:0]}, 1'b1);
        chk({6'h00, s ? {ao_b, ae_b} : {ao_a, ae_a}}, {6'h00, rnd[3], !rnd[5]});
      end
      rnd = lfsr(rnd);
      dir = rnd;
      ctl(8'h00, 8'h00, 1'b1);
      i_host.acc(2'(2 * s), 1'b1, dir, r);
      chk(r, dir);
      chk(s ? pb_e : pa_e, ~dir);
      outv = lfsr(rnd);
      rnd = lfsr(outv);
      if (s) pin_b <= rnd;
      else pin_a <= rnd;
      ctl(8'h04, 8'h04, 1'b1);
      i_host.acc(2'(2 * s), 1'b1, outv, r);
      chk(r, (outv & dir) | (rnd & ~dir));
      chk(s ? pb_o : pa_o, outv);
      ctl(8'h1F, 8'h1F, 1'b1);
      {irq[s], aux[s]} <= 2'h3;
      repeat (6) @(posedge clk);
      ctl(8'h1F, 8'hDF, 1'b0);
      i_host.acc(2'(2 * s), 1'b0, 8'h00, r);
      chk(r, (outv & dir) | (rnd & ~dir));
      ctl(8'h3C, 8'h3C, 1'b1);
      {irq[s], aux[s]} <= 2'h0;
      repeat (6) @(posedge clk);
      ctl(8'h3C, 8'hBC, 1'b1);
      chk({6'h00, s ? {ao_b, ae_b} : {ao_a, ae_a}}, 8'h02);
    end
    report_and_stop();
  end
endmodule
